// ---- dv/sbpt_host_model.sv ----
`timescale 1ns/1ps
module sbpt_host_model
(
  // Clock
  input wire clk,
  // Link pins
  output reg link_sck,
  output reg link_cs_n,
  output reg link_mosi,
  input wire link_miso,
  input wire link_miso_oe
);
  reg [127:0] rx;
  reg oe_seen;
  // Clock idles low between frames
  initial
  begin
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
    rx = 128'h0;
    oe_seen = 1'b0;
  end
  // One frame, 8 system clocks per link bit
  task frame(input [7:0] opc, input [23:0] addr, input integer nb);
    reg [39:0] hdr;
    integer i;
  begin
    hdr = {opc, addr, 8'h00}; // Exactly three address bytes
    oe_seen = 1'b0;
    @(posedge clk);
    link_cs_n <= 1'b0;
    for (i = 0; i < 40 + 8 * nb; i = i + 1)
    begin
      repeat (4) @(posedge clk);
      link_sck <= 1'b0;
      // Toggle once unused so stale data is never mistaken for real
      link_mosi <= (i < 40) ? hdr[39 - i] : ~link_mosi;
      repeat (4) @(posedge clk);
      link_sck <= 1'b1;
      // An undriven line reads as garbage, so late enable shows up
      rx = {rx[126:0], link_miso_oe ? link_miso : ~link_miso};
      if (i >= 40)
        oe_seen = oe_seen | link_miso_oe;
    end
    repeat (4) @(posedge clk);
    link_sck <= 1'b0;
    repeat (4) @(posedge clk);
    link_cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  end
  endtask
endmodule

// ---- dv/sbpt_table_monitor.sv ----
`timescale 1ns/1ps
module sbpt_table_monitor
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [6:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [6:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  // Link pins
  input wire link_sck,
  input wire link_cs_n,
  input wire link_mosi,
  input wire link_miso,
  input wire link_miso_oe
);
  localparam [127:0] tbl = 128'hbb803b08_6b08eb44_01ffffff_fff120e5;
  reg [6:0] ra_reg;
  reg [6:0] wa_reg;
  wire tbl_hit = !ra_reg[6] && ra_reg[1:0] == 2'h0;
  wire bad = ra_reg[1:0] != 2'h0 || ra_reg > 7'h4c;
  // Remember addresses so answers can be judged later
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ra_reg <= 7'h00;
      wa_reg <= 7'h00;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
        ra_reg <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready)
        wa_reg <= s_axi_awaddr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==================================================================
  // Properties
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_tbl;
    s_axi_rvalid && tbl_hit |->
      s_axi_rdata == {24'h0, tbl[8 * ra_reg[5:2] +: 8]} && s_axi_rresp == 2'h0;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table byte wrong");
  property p_rd_err;
    s_axi_rvalid && bad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("bad read accepted");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_wr_err;
    s_axi_bvalid && wa_reg != 7'h4c |-> s_axi_bresp == 2'h2;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("table write taken");
  property p_wr_ok;
    s_axi_bvalid && wa_reg == 7'h4c |-> s_axi_bresp == 2'h0;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("control write refused");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("response dropped");
  property p_oe_off;
    link_cs_n [*6] |-> !link_miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving while idle");
  c_tbl: cover property (s_axi_rvalid && tbl_hit);
  c_wr: cover property (s_axi_bvalid);
  c_oe: cover property (link_miso_oe);
endmodule

bind sbpt_table sbpt_table_monitor mon_u (.clk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .link_sck, .link_cs_n,
  .link_mosi, .link_miso, .link_miso_oe);

// ---- dv/sbpt_tb.sv ----
`timescale 1ns/1ps
module testbench;
  reg clk;
  reg reset_n;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [6:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire link_sck, link_cs_n, link_mosi, link_miso, link_miso_oe;
  integer failures, n_compared, cycles, i;
  reg [31:0] d;
  reg [1:0] r;
  localparam [127:0] tbl_exp = 128'hbb803b08_6b08eb44_01ffffff_fff120e5;
  // Order chosen so every timing byte differs from the one before
  localparam [31:0] opcs = 32'h6bbb3beb;
  localparam [31:0] cycs = 32'h08800844;
  sbpt_table dut_u (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .link_sck,
    .link_cs_n, .link_mosi, .link_miso, .link_miso_oe);
  sbpt_host_model host_u (.clk, .link_sck, .link_cs_n, .link_mosi,
    .link_miso, .link_miso_oe);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==================================================================
  // Helpers
  task end_sim;
  begin
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // A hung handshake must still reach the verdict
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      failures = failures + 1;
      $display("MISMATCH t=%0t timeout", $time);
      end_sim;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task axi_rd(input [6:0] a);
  begin
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  end
  endtask
  task axi_wr(input [6:0] a, input [31:0] v);
  begin
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  end
  endtask
  // ==================================================================
  // Scenarios
  task t_table;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      axi_rd(4 * i);
      chk(d, {24'h0, tbl_exp[8 * i +: 8]});
      chk({30'h0, r}, 32'h0);
    end
  end
  endtask
  // Table writes, misaligned and out-of-range reads are refused and change nothing
  task t_refuse;
  begin
    axi_rd(7'h01);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    axi_rd(7'h50);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    axi_wr(7'h00, 32'h0);
    chk({30'h0, r}, 32'h2);
    axi_rd(7'h00);
    chk(d, 32'he5);
  end
  endtask
  task t_reset;
  begin
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({27'h0, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
      s_axi_rvalid}, 32'h1c);
    axi_rd(7'h04);
    chk(d, 32'h20);
  end
  endtask
  task t_link_table;
  begin
    host_u.frame(8'h5a, 24'h000080, 16);
    for (i = 0; i < 16; i = i + 1)
      chk(host_u.rx[127 - 8 * i -: 8], tbl_exp[8 * i +: 8]);
    chk(host_u.oe_seen, 1);
    host_u.frame(8'h5a, 24'h00008e, 4);
    chk(host_u.rx[31:0], 32'h80bbffff);
  end
  endtask
  // Link disabled: frames dropped as if chip select stayed high
  task t_link_off;
  begin
    axi_wr(7'h4c, 32'h0);
    chk({30'h0, r}, 32'h0);
    axi_rd(7'h4c);
    chk(d, 32'h0);
    host_u.frame(8'h20, 24'h001000, 0);
    host_u.frame(8'h5a, 24'h000080, 1);
    chk(host_u.oe_seen, 0);
    axi_rd(7'h44);
    chk(d, 32'h0);
    axi_rd(7'h40);
    chk(d, 32'h5a);
    axi_wr(7'h4c, 32'h1);
    chk({30'h0, r}, 32'h0);
    axi_rd(7'h4c);
    chk(d, 32'h1);
  end
  endtask
  // Erase counts, each fast read loads its own timing byte
  task t_link_cmds;
  begin
    host_u.frame(8'h20, 24'h001000, 0);
    axi_rd(7'h44);
    chk(d, 32'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      host_u.frame(opcs[8 * i +: 8], 24'h0, 0);
      axi_rd(7'h48);
      chk(d, {24'h0, cycs[8 * i +: 8]});
    end
  end
  endtask
  initial
  begin
    failures = 0;
    n_compared = 0;
    cycles = 0;
    reset_n = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 7'h00;
    s_axi_araddr = 7'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_table;
    t_refuse;
    t_link_table;
    t_link_off;
    t_reset;
    t_link_cmds;
    end_sim;
  end
endmodule

// ---- inc/sbpt_regs.vh ----
`ifndef SBPT_REGS_VH
`define SBPT_REGS_VH

// ==================================================================
// Parameter table contents, relative bytes 0 to 15
`define SBPT_ERASE_AND_STATUS_CAPS 8'he5
`define SBPT_SECTOR_ERASE_OPCODE 8'h20
`define SBPT_READ_MODE_SUPPORT 8'hf1
`define SBPT_CAPS_UNUSED_HIGH 8'hff
`define SBPT_DENSITY_BYTE0 8'hff
`define SBPT_DENSITY_BYTE1 8'hff
`define SBPT_DENSITY_BYTE2 8'hff
`define SBPT_DENSITY_BYTE3 8'h01
`define SBPT_QUAD_IO_READ_CYCLES 8'h44
`define SBPT_QUAD_IO_READ_OPCODE 8'heb
`define SBPT_QUAD_OUT_READ_CYCLES 8'h08
`define SBPT_QUAD_OUT_READ_OPCODE 8'h6b
`define SBPT_DUAL_OUT_READ_CYCLES 8'h08
`define SBPT_DUAL_OUT_READ_OPCODE 8'h3b
`define SBPT_DUAL_IO_READ_CYCLES 8'h80
`define SBPT_DUAL_IO_READ_OPCODE 8'hbb

// ==================================================================
// Table indices (printed offsets); bus byte address is four times these
`define SBPT_IDX_ERASE_AND_STATUS_CAPS 4'h0
`define SBPT_IDX_SECTOR_ERASE_OPCODE 4'h1
`define SBPT_IDX_READ_MODE_SUPPORT 4'h2
`define SBPT_IDX_CAPS_UNUSED_HIGH 4'h3
`define SBPT_IDX_DENSITY_BYTE0 4'h4
`define SBPT_IDX_DENSITY_BYTE1 4'h5
`define SBPT_IDX_DENSITY_BYTE2 4'h6
`define SBPT_IDX_DENSITY_BYTE3 4'h7
`define SBPT_IDX_QUAD_IO_READ_CYCLES 4'h8
`define SBPT_IDX_QUAD_IO_READ_OPCODE 4'h9
`define SBPT_IDX_QUAD_OUT_READ_CYCLES 4'ha
`define SBPT_IDX_QUAD_OUT_READ_OPCODE 4'hb
`define SBPT_IDX_DUAL_OUT_READ_CYCLES 4'hc
`define SBPT_IDX_DUAL_OUT_READ_OPCODE 4'hd
`define SBPT_IDX_DUAL_IO_READ_CYCLES 4'he
`define SBPT_IDX_DUAL_IO_READ_OPCODE 4'hf

// ==================================================================
// Extra registers, byte addresses
`define SBPT_ADDR_LINK_STATUS 7'h40
`define SBPT_ADDR_ERASE_COUNT 7'h44
`define SBPT_ADDR_READ_TIMING 7'h48
`define SBPT_ADDR_LINK_CTRL 7'h4c
`define SBPT_LINK_CTRL_RESET 1'h1

// ==================================================================
// Link side constants
`define SBPT_TABLE_BASE 24'h000080
`define SBPT_TABLE_LEN_DW 8'h10
`define SBPT_OPC_PARAM_READ 8'h5a
`define SBPT_PARAM_DUMMY_BITS 5'h08
`define SBPT_FILL_BYTE 8'hff

// ==================================================================
// Bus responses
`define SBPT_RESP_OKAY 2'h0
`define SBPT_RESP_SLVERR 2'h2

`endif

// ---- verilog/sbpt_table.v ----
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sbpt_regs.vh"

module sbpt_table
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [6:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [6:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Serial flash link pins
  input wire link_sck,
  input wire link_cs_n,
  input wire link_mosi,
  output wire link_miso,
  output wire link_miso_oe
);

  // ================================================================
  // Link frame states
  localparam ST_OPC = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_SKIP = 3'h4;

  // ================================================================
  // Fixed table lookup, no storage so nothing can overwrite it
  function [7:0] tbl_byte;
    input [3:0] idx;
    case (idx)
      `SBPT_IDX_ERASE_AND_STATUS_CAPS:
        tbl_byte = `SBPT_ERASE_AND_STATUS_CAPS;
      `SBPT_IDX_SECTOR_ERASE_OPCODE:
        tbl_byte = `SBPT_SECTOR_ERASE_OPCODE;
      `SBPT_IDX_READ_MODE_SUPPORT:
        tbl_byte = `SBPT_READ_MODE_SUPPORT;
      `SBPT_IDX_CAPS_UNUSED_HIGH:
        tbl_byte = `SBPT_CAPS_UNUSED_HIGH;
      `SBPT_IDX_DENSITY_BYTE0:
        tbl_byte = `SBPT_DENSITY_BYTE0;
      `SBPT_IDX_DENSITY_BYTE1:
        tbl_byte = `SBPT_DENSITY_BYTE1;
      `SBPT_IDX_DENSITY_BYTE2:
        tbl_byte = `SBPT_DENSITY_BYTE2;
      `SBPT_IDX_DENSITY_BYTE3:
        tbl_byte = `SBPT_DENSITY_BYTE3;
      `SBPT_IDX_QUAD_IO_READ_CYCLES:
        tbl_byte = `SBPT_QUAD_IO_READ_CYCLES;
      `SBPT_IDX_QUAD_IO_READ_OPCODE:
        tbl_byte = `SBPT_QUAD_IO_READ_OPCODE;
      `SBPT_IDX_QUAD_OUT_READ_CYCLES:
        tbl_byte = `SBPT_QUAD_OUT_READ_CYCLES;
      `SBPT_IDX_QUAD_OUT_READ_OPCODE:
        tbl_byte = `SBPT_QUAD_OUT_READ_OPCODE;
      `SBPT_IDX_DUAL_OUT_READ_CYCLES:
        tbl_byte = `SBPT_DUAL_OUT_READ_CYCLES;
      `SBPT_IDX_DUAL_OUT_READ_OPCODE:
        tbl_byte = `SBPT_DUAL_OUT_READ_OPCODE;
      `SBPT_IDX_DUAL_IO_READ_CYCLES:
        tbl_byte = `SBPT_DUAL_IO_READ_CYCLES;
      `SBPT_IDX_DUAL_IO_READ_OPCODE:
        tbl_byte = `SBPT_DUAL_IO_READ_OPCODE;
      default: tbl_byte = `SBPT_FILL_BYTE;
    endcase
  endfunction

  // Byte seen at a parameter-space address
  function [7:0] space_byte;
    input [23:0] addr;
    reg [23:0] rel;
    begin
      rel = addr - `SBPT_TABLE_BASE;
      // Later dwords of the table live elsewhere and read as fill
      if (addr >= `SBPT_TABLE_BASE && rel < 24'h000010)
        space_byte = tbl_byte(rel[3:0]);
      else
        space_byte = `SBPT_FILL_BYTE;
    end
  endfunction

  // ================================================================
  // Bus side state
  reg awready_reg;
  reg wready_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [6:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg link_en_reg;

  // Link side state
  reg [2:0] sck_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [2:0] state_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] opc_sh_reg;
  reg [23:0] addr_reg;
  reg [7:0] data_sh_reg;
  reg miso_reg;
  reg miso_oe_reg;
  reg [7:0] last_opc_reg;
  reg [15:0] erase_cnt_reg;
  reg [7:0] timing_reg;

  wire sck_rise;
  wire sck_fall;
  wire in_frame;
  wire [7:0] opc_full;
  wire [6:0] raddr;
  wire [31:0] rd_word;
  wire rd_hit;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign link_miso = miso_reg;
  assign link_miso_oe = miso_oe_reg;

  // ================================================================
  // Read decode; table bytes in the low lane, upper bits zero
  assign raddr = s_axi_araddr;
  assign rd_hit = (raddr[1:0] == 2'h0) && (raddr <= `SBPT_ADDR_LINK_CTRL);
  assign rd_word =
    !raddr[6] ? {24'h000000, tbl_byte(raddr[5:2])} :
    (raddr == `SBPT_ADDR_LINK_STATUS) ?
      {20'h00000, miso_oe_reg, state_reg, last_opc_reg[7:0]} :
    (raddr == `SBPT_ADDR_ERASE_COUNT) ? {16'h0000, erase_cnt_reg} :
    (raddr == `SBPT_ADDR_READ_TIMING) ? {24'h000000, timing_reg} :
    {31'h00000000, link_en_reg};

  // ================================================================
  // Read channel: one read in flight, answer one cycle after taking
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SBPT_RESP_OKAY;
    end
    else if (rvalid_reg)
    begin
      if (s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_hit ? rd_word : 32'h00000000;
      rresp_reg <= rd_hit ? `SBPT_RESP_OKAY : `SBPT_RESP_SLVERR;
    end
  end

  // ================================================================
  // Write channel: address and data in either order, then response
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SBPT_RESP_OKAY;
      waddr_reg <= 7'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      link_en_reg <= `SBPT_LINK_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        waddr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (aw_got_reg && w_got_reg && !bvalid_reg)
      begin
        bvalid_reg <= 1'b1;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        // Only the control word is writable; table stays fixed
        if (waddr_reg == `SBPT_ADDR_LINK_CTRL)
        begin
          bresp_reg <= `SBPT_RESP_OKAY;
          if (wstrb_reg[0])
            link_en_reg <= wdata_reg[0];
        end
        else
          bresp_reg <= `SBPT_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ================================================================
  // Link pin synchronisers; third sck stage only feeds edge finding
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], link_sck};
      cs_sync_reg <= {cs_sync_reg[0], link_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], link_mosi};
    end
  end

  assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
  assign sck_fall = !sck_sync_reg[1] && sck_sync_reg[2];
  assign in_frame = !cs_sync_reg[1] && link_en_reg;
  assign opc_full = {opc_sh_reg[6:0], mosi_sync_reg[1]};

  // ================================================================
  // Link command engine, mode 0, single-bit data out
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_OPC;
      bit_cnt_reg <= 5'h00;
      opc_sh_reg <= 8'h00;
      addr_reg <= 24'h000000;
      data_sh_reg <= 8'h00;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      last_opc_reg <= 8'h00;
      erase_cnt_reg <= 16'h0000;
      timing_reg <= 8'h00;
    end
    else if (!in_frame)
    begin
      // Frame end (or link disabled) drops everything mid-command
      state_reg <= ST_OPC;
      bit_cnt_reg <= 5'h00;
      miso_oe_reg <= 1'b0;
    end
    else if (sck_rise)
    begin
      case (state_reg)
        ST_OPC:
        begin
          opc_sh_reg <= opc_full;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'h07)
          begin
            bit_cnt_reg <= 5'h00;
            last_opc_reg <= opc_full;
            case (opc_full)
              `SBPT_OPC_PARAM_READ: state_reg <= ST_ADDR;
              `SBPT_SECTOR_ERASE_OPCODE:
              begin
                // Array is not here; erase is logged, table untouched
                erase_cnt_reg <= erase_cnt_reg + 16'h0001;
                state_reg <= ST_SKIP;
              end
              `SBPT_QUAD_IO_READ_OPCODE:
              begin
                timing_reg <= `SBPT_QUAD_IO_READ_CYCLES;
                state_reg <= ST_SKIP;
              end
              `SBPT_QUAD_OUT_READ_OPCODE:
              begin
                timing_reg <= `SBPT_QUAD_OUT_READ_CYCLES;
                state_reg <= ST_SKIP;
              end
              `SBPT_DUAL_OUT_READ_OPCODE:
              begin
                timing_reg <= `SBPT_DUAL_OUT_READ_CYCLES;
                state_reg <= ST_SKIP;
              end
              `SBPT_DUAL_IO_READ_OPCODE:
              begin
                timing_reg <= `SBPT_DUAL_IO_READ_CYCLES;
                state_reg <= ST_SKIP;
              end
              default: state_reg <= ST_SKIP;
            endcase
          end
        end
        ST_ADDR:
        begin
          addr_reg <= {addr_reg[22:0], mosi_sync_reg[1]};
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          // Exactly three address bytes
          if (bit_cnt_reg == 5'h17)
          begin
            bit_cnt_reg <= 5'h00;
            state_reg <= ST_DUMMY;
          end
        end
        ST_DUMMY:
        begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == `SBPT_PARAM_DUMMY_BITS - 5'h01)
          begin
            bit_cnt_reg <= 5'h00;
            data_sh_reg <= space_byte(addr_reg);
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: state_reg <= ST_DATA;
        ST_SKIP: state_reg <= ST_SKIP;
        default: state_reg <= ST_SKIP;
      endcase
    end
    else if (sck_fall && state_reg == ST_DATA)
    begin
      // Drive on falling edge so host samples a settled bit
      miso_oe_reg <= 1'b1;
      miso_reg <= data_sh_reg[7];
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == 5'h07)
      begin
        bit_cnt_reg <= 5'h00;
        addr_reg <= addr_reg + 24'h000001;
        data_sh_reg <= space_byte(addr_reg + 24'h000001);
      end
      else
        data_sh_reg <= {data_sh_reg[6:0], 1'b0};
    end
  end

endmodule
